// ==== dmpm_dwell.sv ====
// Sets its flag once cond has held for more than limit_ms whole milliseconds
module dmpm_dwell
  import dmpm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ms_tick,
  input  wire logic        cond,
  input  wire logic [15:0] limit_ms,
  output logic             flag
);

  logic [16:0] cnt_r;

  // Count ms while the condition holds, restart from zero when it drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 17'h00000;
    end else if (!cond) begin
      cnt_r <= 17'h00000;
    end else if (ms_tick && (cnt_r <= {1'b0, limit_ms})) begin
      cnt_r <= cnt_r + 17'h00001;
    end
  end

  // Saturated count past the limit means strictly longer than the dwell
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
    end else begin
      flag <= cond && (cnt_r > {1'b0, limit_ms});
    end
  end

endmodule // dmpm_dwell

// ==== dmpm_loop_model.sv ====
// Control-loop stand-in on the far side of the mode offer
module dmpm_loop_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic mode_change,
  input  wire logic slow,
  output logic      mode_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;

  // Takes every offered code; a slow loop stalls so the hold is exercised
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ack <= 1'h0;
      wait_cnt <= 0;
    end else if (mode_change && !mode_ack) begin
      if (wait_cnt >= (slow ? 2 : 0)) begin
        mode_ack <= 1'h1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      mode_ack <= 1'h0;
    end
  end
endmodule // dmpm_loop_model

// ==== dmpm_pkg.sv ====
// Summary of operation
// - On an error, stop by fault code: 0 coast, 1 slow ramp, 2 quick ramp.
// - Mode codes: -2 setup, -1 clock-dir, 0 none, 1..10 modes, 5 reserved.
// - Active operating mode reads back separately with the same encoding.
// - Commanded position reads as a signed 32-bit value in user units.
// - Raw encoder position is reported and is never zeroed by homing.
// - Raw encoder position is flagged invalid while encoder resolution is zero.
// - Measured position reads as a signed 32-bit user-unit value from feedback.
// - Status bit 13 sets when following error exceeds limit longer than delay.
// - Tracking limit of all ones disables following-error supervision.
// - With a reaction configured, a following error also logs an error entry.
// - Following-error delay counts in milliseconds.
// - Following-error limit is symmetric around the commanded position.
// - Status bit 10 sets when inside band around target longer than dwell.
// - Target band of all ones disables target-reached supervision.
// - Target band is symmetric and only evaluated in profile/interpolated position.
// - Target dwell counts in milliseconds.
// - On a fault the stop action code decides how the motor stops.
package dmpm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_FAULT_STOP_ACTION = 16'h605E;
  localparam logic [15:0] IDX_REQ_MODE          = 16'h6060;
  localparam logic [15:0] IDX_ACT_MODE          = 16'h6061;
  localparam logic [15:0] IDX_CMD_POS           = 16'h6062;
  localparam logic [15:0] IDX_RAW_POS           = 16'h6063;
  localparam logic [15:0] IDX_MEAS_POS          = 16'h6064;
  localparam logic [15:0] IDX_TRK_LIMIT         = 16'h6065;
  localparam logic [15:0] IDX_TRK_DELAY         = 16'h6066;
  localparam logic [15:0] IDX_TGT_BAND          = 16'h6067;
  localparam logic [15:0] IDX_TGT_DWELL         = 16'h6068;
  localparam logic [15:0] IDX_STATUS            = 16'h6080;

  // Reset values
  localparam logic [15:0] RST_FAULT_STOP_ACTION = 16'h0002;
  localparam logic [7:0]  RST_REQ_MODE          = 8'h00;
  localparam logic [31:0] RST_TRK_LIMIT         = 32'h0000_0100;
  localparam logic [15:0] RST_TRK_DELAY         = 16'h0064;
  localparam logic [31:0] RST_TGT_BAND          = 32'h0000_000A;
  localparam logic [15:0] RST_TGT_DWELL         = 16'h0064;
  localparam logic [31:0] WINDOW_OFF            = 32'hFFFF_FFFF;

  // Fault stop action codes
  localparam logic [15:0] FSA_COAST = 16'h0000;
  localparam logic [15:0] FSA_SLOW  = 16'h0001;
  localparam logic [15:0] FSA_QUICK = 16'h0002;

  // Operating mode codes (signed 8-bit)
  localparam logic [7:0] MODE_AUTO_SETUP = 8'hFE;
  localparam logic [7:0] MODE_CLK_DIR    = 8'hFF;
  localparam logic [7:0] MODE_NONE       = 8'h00;
  localparam logic [7:0] MODE_PROF_POS   = 8'h01;
  localparam logic [7:0] MODE_RESERVED   = 8'h05;
  localparam logic [7:0] MODE_INTERP_POS = 8'h07;
  localparam logic [7:0] MODE_CS_TORQUE  = 8'h0A;

  // Status word bit positions
  localparam int unsigned STS_TGT_BIT = 10;
  localparam int unsigned STS_FE_BIT  = 13;
  localparam int unsigned STS_RAW_BIT = 0;

  // Timing: one millisecond at 125 MHz
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_PER_SEC    = 1_000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_SEC;

  typedef enum logic [1:0] {
    DMPM_STOP_COAST,
    DMPM_STOP_SLOW,
    DMPM_STOP_QUICK
  } dmpm_stop_e;

  // Positions supplied by the control loop, same clock
  typedef struct packed {
    logic [31:0] demand;
    logic [31:0] target;
    logic [31:0] actual;
    logic [31:0] raw;
  } dmpm_pos_s;

  // Supervision results
  typedef struct packed {
    logic following_error;
    logic target_reached;
    logic raw_valid;
  } dmpm_status_s;

endpackage : dmpm_pkg

// ==== dmpm_top.sv ====
// Mode selection and position supervision with an AHB-Lite register port
//
// The AHB-Lite slave port was decided locally.
module dmpm_top
  import dmpm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
)(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Control loop side
  input  wire dmpm_pos_s    pos_in,
  input  wire logic         homing_done,
  input  wire logic         enc_res_zero,
  input  wire logic         fault_event,
  input  wire logic         fe_reaction_en,
  input  wire logic         mode_ack,
  // Results
  output dmpm_status_s      status,
  output logic [7:0]        mode_request,
  output logic              mode_change,
  output logic              stop_req,
  output dmpm_stop_e        stop_kind,
  output logic              fe_reaction,
  output logic              err_log
);

  localparam int unsigned MSW = $clog2(MS_CYCLES + 1);

  // Refuse a divider that cannot give a tick
  generate
    if (MS_CYCLES < 2) begin : g_bad_div
      $error("MS_CYCLES must be at least 2");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  logic        ap_valid;
  logic        dp_wr_r;
  logic        dp_rd_r;
  logic [15:0] dp_idx_r;
  logic        dp_hit_r;
  logic        addr_hit;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_valid  = hsel && htrans[1] && hready;
  // Upper address bits must be zero so aliases do not decode
  assign addr_hit  = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);

  // Capture the address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r  <= 1'b0;
      dp_rd_r  <= 1'b0;
      dp_idx_r <= 16'h0000;
      dp_hit_r <= 1'b0;
    end else if (hready) begin
      dp_wr_r  <= ap_valid && hwrite;
      dp_rd_r  <= ap_valid && !hwrite;
      dp_idx_r <= haddr[17:2];
      dp_hit_r <= addr_hit;
    end
  end

  logic wr_fsa;
  logic wr_mode;
  logic wr_trk_lim;
  logic wr_trk_dly;
  logic wr_band;
  logic wr_dwell;

  assign wr_fsa     = dp_wr_r && dp_hit_r && (dp_idx_r == IDX_FAULT_STOP_ACTION);
  assign wr_mode    = dp_wr_r && dp_hit_r && (dp_idx_r == IDX_REQ_MODE);
  assign wr_trk_lim = dp_wr_r && dp_hit_r && (dp_idx_r == IDX_TRK_LIMIT);
  assign wr_trk_dly = dp_wr_r && dp_hit_r && (dp_idx_r == IDX_TRK_DELAY);
  assign wr_band    = dp_wr_r && dp_hit_r && (dp_idx_r == IDX_TGT_BAND);
  assign wr_dwell   = dp_wr_r && dp_hit_r && (dp_idx_r == IDX_TGT_DWELL);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [15:0] fault_stop_action_r;
  logic [7:0]  requested_operating_mode_r;
  logic [31:0] tracking_error_limit_r;
  logic [15:0] tracking_error_delay_r;
  logic [31:0] target_reached_band_r;
  logic [15:0] target_reached_dwell_r;
  logic        fsa_legal;

  // Reserved stop codes are refused so a fault always has a defined stop
  assign fsa_legal = (hwdata[15:0] == FSA_COAST) || (hwdata[15:0] == FSA_SLOW)
                  || (hwdata[15:0] == FSA_QUICK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_stop_action_r <= RST_FAULT_STOP_ACTION;
    end else if (wr_fsa && fsa_legal) begin
      fault_stop_action_r <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      requested_operating_mode_r <= RST_REQ_MODE;
    end else if (wr_mode) begin
      requested_operating_mode_r <= hwdata[7:0];
    end
  end

  // Supervision windows and times
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tracking_error_limit_r <= RST_TRK_LIMIT;
      tracking_error_delay_r <= RST_TRK_DELAY;
      target_reached_band_r  <= RST_TGT_BAND;
      target_reached_dwell_r <= RST_TGT_DWELL;
    end else begin
      if (wr_trk_lim) begin
        tracking_error_limit_r <= hwdata;
      end
      if (wr_trk_dly) begin
        tracking_error_delay_r <= hwdata[15:0];
      end
      if (wr_band) begin
        target_reached_band_r <= hwdata;
      end
      if (wr_dwell) begin
        target_reached_dwell_r <= hwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Operating mode: request toward the loop, active mode from it
  // ---------------------------------------------------------------
  logic [7:0] active_operating_mode_r;
  logic       mode_legal;
  logic       mode_pend_r;

  // Code 0 keeps the present mode; reserved and out-of-range codes are ignored
  assign mode_legal = ($signed(requested_operating_mode_r) >= $signed(MODE_AUTO_SETUP))
                   && ($signed(requested_operating_mode_r) <= $signed(MODE_CS_TORQUE))
                   && (requested_operating_mode_r != MODE_NONE)
                   && (requested_operating_mode_r != MODE_RESERVED);

  assign mode_request = requested_operating_mode_r;
  assign mode_change  = mode_pend_r;

  // A new legal request is offered until the loop acknowledges it or the request is rewritten
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_pend_r <= 1'b0;
    end else if (mode_pend_r && mode_ack) begin
      mode_pend_r <= 1'b0;
    end else if (wr_mode) begin
      mode_pend_r <= 1'b0;
    end else if (mode_legal && (requested_operating_mode_r != active_operating_mode_r)) begin
      mode_pend_r <= 1'b1;
    end
  end

  // Only an acknowledged change becomes the mode in effect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_operating_mode_r <= MODE_NONE;
    end else if (mode_pend_r && mode_ack) begin
      active_operating_mode_r <= requested_operating_mode_r;
    end
  end

  // ---------------------------------------------------------------
  // Positions
  // ---------------------------------------------------------------
  logic [31:0] home_ofs_r;
  logic [31:0] commanded_position_r;
  logic [31:0] measured_position_r;
  logic [31:0] raw_encoder_position_r;
  logic [31:0] target_user_r;
  logic        raw_valid_r;

  // Homing zeroes the user-unit view by remembering the home point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      home_ofs_r <= 32'h0000_0000;
    end else if (homing_done) begin
      home_ofs_r <= pos_in.actual;
    end
  end

  // User-unit positions relative to home; raw counts pass untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      commanded_position_r   <= 32'h0000_0000;
      measured_position_r    <= 32'h0000_0000;
      target_user_r          <= 32'h0000_0000;
      raw_encoder_position_r <= 32'h0000_0000;
    end else if (homing_done) begin
      commanded_position_r   <= 32'h0000_0000;
      measured_position_r    <= 32'h0000_0000;
      target_user_r          <= pos_in.target - pos_in.actual;
      raw_encoder_position_r <= pos_in.raw;
    end else begin
      commanded_position_r   <= pos_in.demand - home_ofs_r;
      measured_position_r    <= pos_in.actual - home_ofs_r;
      target_user_r          <= pos_in.target - home_ofs_r;
      raw_encoder_position_r <= pos_in.raw;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_valid_r <= 1'b0;
    end else begin
      raw_valid_r <= !enc_res_zero;
    end
  end

  // ---------------------------------------------------------------
  // Millisecond enable
  // ---------------------------------------------------------------
  logic [MSW-1:0] ms_cnt_r;
  logic           ms_tick;

  assign ms_tick = (ms_cnt_r == MSW'(MS_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_r <= '0;
    end else if (ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + MSW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Supervision conditions, magnitudes in 33 bits to avoid wrap
  // ---------------------------------------------------------------
  logic signed [32:0] fe_diff;
  logic signed [32:0] tr_diff;
  logic        [32:0] fe_mag;
  logic        [32:0] tr_mag;
  logic               fe_cond;
  logic               tr_cond;
  logic               pos_mode;

  assign fe_diff = $signed({measured_position_r[31], measured_position_r})
                 - $signed({commanded_position_r[31], commanded_position_r});
  assign tr_diff = $signed({measured_position_r[31], measured_position_r})
                 - $signed({target_user_r[31], target_user_r});
  assign fe_mag  = fe_diff[32] ? 33'(-fe_diff) : 33'(fe_diff);
  assign tr_mag  = tr_diff[32] ? 33'(-tr_diff) : 33'(tr_diff);

  assign pos_mode = (active_operating_mode_r == MODE_PROF_POS)
                 || (active_operating_mode_r == MODE_INTERP_POS);

  assign fe_cond = (tracking_error_limit_r != WINDOW_OFF)
                && (fe_mag > {1'b0, tracking_error_limit_r});
  assign tr_cond = (target_reached_band_r != WINDOW_OFF)
                && pos_mode
                && (tr_mag < {1'b0, target_reached_band_r});

  logic fe_flag;
  logic tr_flag;
  logic fe_flag_d_r;

  dmpm_dwell u_fe_dwell (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ms_tick  (ms_tick),
    .cond     (fe_cond),
    .limit_ms (tracking_error_delay_r),
    .flag     (fe_flag)
  );

  dmpm_dwell u_tr_dwell (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ms_tick  (ms_tick),
    .cond     (tr_cond),
    .limit_ms (target_reached_dwell_r),
    .flag     (tr_flag)
  );

  assign status.following_error = fe_flag;
  assign status.target_reached  = tr_flag;
  assign status.raw_valid       = raw_valid_r;

  // Rising edge of the following error drives reaction and history entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fe_flag_d_r <= 1'b0;
      fe_reaction <= 1'b0;
      err_log     <= 1'b0;
    end else begin
      fe_flag_d_r <= fe_flag;
      fe_reaction <= fe_flag && !fe_flag_d_r && fe_reaction_en;
      err_log     <= fe_flag && !fe_flag_d_r && fe_reaction_en;
    end
  end

  // ---------------------------------------------------------------
  // Fault stop: one pulse with the stop kind held until the next fault
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_req  <= 1'b0;
      stop_kind <= DMPM_STOP_QUICK;
    end else begin
      stop_req <= fault_event;
      if (fault_event) begin
        unique case (fault_stop_action_r)
          FSA_COAST: stop_kind <= DMPM_STOP_COAST;
          FSA_SLOW:  stop_kind <= DMPM_STOP_SLOW;
          default:   stop_kind <= DMPM_STOP_QUICK;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux in the data phase; unmapped addresses read zero
  // ---------------------------------------------------------------
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_rd_r && dp_hit_r) begin
      unique case (dp_idx_r)
        IDX_FAULT_STOP_ACTION: hrdata = {16'h0000, fault_stop_action_r};
        IDX_REQ_MODE:          hrdata = {24'h000000, requested_operating_mode_r};
        IDX_ACT_MODE:          hrdata = {24'h000000, active_operating_mode_r};
        IDX_CMD_POS:           hrdata = commanded_position_r;
        IDX_RAW_POS:           hrdata = raw_encoder_position_r;
        IDX_MEAS_POS:          hrdata = measured_position_r;
        IDX_TRK_LIMIT:         hrdata = tracking_error_limit_r;
        IDX_TRK_DELAY:         hrdata = {16'h0000, tracking_error_delay_r};
        IDX_TGT_BAND:          hrdata = target_reached_band_r;
        IDX_TGT_DWELL:         hrdata = {16'h0000, target_reached_dwell_r};
        IDX_STATUS: begin
          hrdata[STS_FE_BIT]  = fe_flag;
          hrdata[STS_TGT_BIT] = tr_flag;
          hrdata[STS_RAW_BIT] = raw_valid_r;
        end
        default:               hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // dmpm_top

// ==== dmpm_top_sva.sv ====
// Port-level checks of the supervision block
module dmpm_chk
  import dmpm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
)(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         hsel,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  input wire dmpm_status_s status,
  input wire logic         enc_res_zero,
  input wire logic         fault_event,
  input wire logic         stop_req,
  input wire dmpm_stop_e   stop_kind,
  input wire logic         fe_reaction_en,
  input wire logic         fe_reaction,
  input wire logic         err_log,
  input wire logic         mode_change,
  input wire logic         mode_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_ph_r;

  // Marks the read data phase; hrdata must be quiet elsewhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_r <= 1'h0;
    end else if (hready) begin
      rd_ph_r <= hsel && htrans[1] && !hwrite;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_rdata_idle: assert property (!rd_ph_r |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  chk_stop_next: assert property (fault_event |=> stop_req)
    else $error("no stop request after a fault");
  chk_kind_held: assert property (!fault_event |=> $stable(stop_kind))
    else $error("stop kind changed without a fault");
  chk_raw_flag: assert property (hresetn |=> status.raw_valid == !$past(enc_res_zero))
    else $error("raw valid flag does not follow resolution");
  chk_log_pair: assert property (fe_reaction |-> err_log)
    else $error("reaction without error entry");
  chk_react_pulse: assert property (fe_reaction |=> !fe_reaction)
    else $error("reaction longer than one cycle");
  chk_fe_rise: assert property ($rose(status.following_error) && fe_reaction_en
    |-> ##[0:1] err_log)
    else $error("following error not logged");
  chk_mode_hold: assert property (mode_change && !mode_ack |=> mode_change)
    else $error("mode offer withdrawn before acceptance");
  chk_mode_take: assert property (mode_change && mode_ack |=> !mode_change)
    else $error("mode offer kept after acceptance");
endmodule // dmpm_chk

bind dmpm_top dmpm_chk #(.MS_CYCLES(MS_CYCLES)) u_dmpm_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .status(status), .enc_res_zero(enc_res_zero),
  .fault_event(fault_event), .stop_req(stop_req), .stop_kind(stop_kind),
  .fe_reaction_en(fe_reaction_en), .fe_reaction(fe_reaction), .err_log(err_log),
  .mode_change(mode_change), .mode_ack(mode_ack));

// ==== dmpm_top_tb.sv ====
module dmpm_top_tb;
  import dmpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  localparam logic [15:0] RIDX [10] = '{IDX_FAULT_STOP_ACTION, IDX_REQ_MODE, IDX_ACT_MODE,
    IDX_CMD_POS, IDX_RAW_POS, IDX_MEAS_POS, IDX_TRK_LIMIT, IDX_TRK_DELAY, IDX_TGT_BAND,
    IDX_TGT_DWELL};
  localparam logic [31:0] RVAL [10] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h100, 32'h64, 32'hA, 32'h64};
  logic         hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, fsa, v;
  logic         hready, hresp, mode_ack, slow = 1'h0, rd_ph = 1'h0;
  logic         homing_done = 1'h0, enc_res_zero = 1'h0, fault_event = 1'h0;
  logic         fe_reaction_en = 1'h1, mode_change, stop_req, fe_reaction, err_log;
  logic [7:0]   mode_request, act = 8'h0;
  dmpm_pos_s    pos = '0;
  dmpm_status_s status;
  dmpm_stop_e   stop_kind;
  logic [31:0]  exp_q [$];
  string        name_q [$];
  int           failures = 0, tests_run = 0, cyc = 0, logs = 0;
  integer       seed = 32'hE36AC528;

  always #4 hclk = ~hclk;

  dmpm_top #(.MS_CYCLES(MS)) u_dmpm_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pos_in(pos),
    .homing_done(homing_done), .enc_res_zero(enc_res_zero), .fault_event(fault_event),
    .fe_reaction_en(fe_reaction_en), .mode_ack(mode_ack), .status(status),
    .mode_request(mode_request), .mode_change(mode_change), .stop_req(stop_req),
    .stop_kind(stop_kind), .fe_reaction(fe_reaction), .err_log(err_log));
  dmpm_loop_model u_dmpm_loop_model (.hclk(hclk), .hresetn(hresetn),
    .mode_change(mode_change), .slow(slow), .mode_ack(mode_ack));

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic note(input string nm, input logic [31:0] e);
    name_q.push_back(nm);
    exp_q.push_back(e);
  endtask

  // One single transfer; each phase is held until hready is seen high
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= w ? d : $random(seed);
    do @(posedge hclk); while (hready !== 1'h1);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'h1, idx, d);
  endtask

  task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] e);
    note(nm, e);
    bus(1'h0, idx, 32'h0);
  endtask

  task automatic rd_sts(input logic f, input logic t);
    rd("status", IDX_STATUS, {18'h0, f, 2'h0, t, 9'h0, !enc_res_zero});
  endtask

  // Status just before the shortest dwell can end, and after the longest
  task automatic sup(input dmpm_pos_s p, input logic f0, t0, f1, t1);
    pos <= p;
    repeat (2 * MS - 4) @(posedge hclk);
    rd_sts(f0, t0);
    repeat (3 * MS - 4) @(posedge hclk);
    rd_sts(f1, t1);
  endtask

  // Scoreboard: each result seen takes the oldest note off the queue
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (err_log === 1'h1)
      logs <= logs + 1;
    if (rd_ph && hready === 1'h1)
      check(name_q.pop_front(), exp_q.pop_front(), hrdata);
    if (stop_req === 1'h1)
      check(name_q.pop_front(), exp_q.pop_front(), {30'h0, stop_kind});
    if (hready === 1'h1)
      rd_ph <= hsel && htrans[1] && !hwrite;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (int i = 0; i < 10; i++)
      rd("reset_value", RIDX[i], RVAL[i]);
    // Settings written and read back at once; 16-bit ones keep the low half
    for (int i = 6; i < 10; i++) begin
      v = $random(seed);
      if (i[0])
        v[31:16] = 16'h0;
      wr(RIDX[i], v);
      rd("setting", RIDX[i], v);
    end
    wr(IDX_ACT_MODE, 32'h7);
    rd("act_mode_ro", IDX_ACT_MODE, 32'h0);
    wr(IDX_CMD_POS, $random(seed));
    rd("cmd_pos_ro", IDX_CMD_POS, 32'h0);
    wr(16'h6069, 32'hFFFF_FFFF);
    rd("unmapped", 16'h6069, 32'h0);
    // Every stop code, then a reserved one that leaves the last kept
    fsa = 32'h2;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_FAULT_STOP_ACTION, c);
      if (c < 3)
        fsa = c;
      rd("fault_action", IDX_FAULT_STOP_ACTION, fsa);
      note("stop_kind", fsa);
      fault_event <= 1'h1;
      @(posedge hclk);
      fault_event <= 1'h0;
      @(posedge hclk);
    end
    // Every mode code; 0 and 5 leave the active mode alone
    for (int m = -2; m < 11; m++) begin
      slow <= m[0];
      wr(IDX_REQ_MODE, {24'h0, m[7:0]});
      repeat (8) @(posedge hclk);
      if (m != 0 && m != 5)
        act = m[7:0];
      check("mode_request", {24'h0, m[7:0]}, {24'h0, mode_request});
      rd("req_mode", IDX_REQ_MODE, {24'h0, m[7:0]});
      rd("act_mode", IDX_ACT_MODE, {24'h0, act});
    end
    pos <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge hclk);
    rd("cmd_pos", IDX_CMD_POS, pos.demand);
    rd("meas_pos", IDX_MEAS_POS, pos.actual);
    rd("raw_pos", IDX_RAW_POS, pos.raw);
    homing_done <= 1'h1;
    @(posedge hclk);
    homing_done <= 1'h0;
    @(posedge hclk);
    rd("cmd_homed", IDX_CMD_POS, pos.demand - pos.actual);
    rd("meas_homed", IDX_MEAS_POS, 32'h0);
    rd("raw_homed", IDX_RAW_POS, pos.raw);
    // Limit 100, band 10, 2 ms dwell each, profile position mode
    pos <= {32'h0, 32'h3E8, 32'h0, 32'h5};
    wr(IDX_TRK_LIMIT, 32'h64);
    wr(IDX_TRK_DELAY, 32'h2);
    wr(IDX_TGT_BAND, 32'hA);
    wr(IDX_TGT_DWELL, 32'h2);
    wr(IDX_REQ_MODE, 32'h1);
    repeat (8) @(posedge hclk);
    sup({32'h0, 32'h3E8, 32'h65, 32'h5}, 0, 0, 1, 0);
    sup({32'h0, 32'h3E8, 32'hFFFF_FF9B, 32'h5}, 1, 0, 1, 0);
    check("err_log", 32'h1, logs);
    enc_res_zero <= 1'h1;
    sup({32'h0, 32'h3C, 32'h64, 32'h5}, 0, 0, 0, 0);
    enc_res_zero <= 1'h0;
    sup({32'h0, 32'h9, 32'h0, 32'h5}, 0, 0, 0, 1);
    sup({32'h0, 32'hFFFF_FFF6, 32'h0, 32'h5}, 0, 0, 0, 0);
    sup({32'h0, 32'hFFFF_FFF7, 32'h0, 32'h5}, 0, 0, 0, 1);
    // Velocity mode ignores the band; interpolated position uses it
    for (int k = 0; k < 2; k++) begin
      pos <= {32'h0, 32'h3E8, 32'h0, 32'h5};
      wr(IDX_REQ_MODE, k ? 32'h7 : 32'h2);
      repeat (8) @(posedge hclk);
      sup({32'h0, 32'h9, 32'h0, 32'h5}, 0, 0, 0, k);
    end
    wr(IDX_TRK_LIMIT, 32'hFFFF_FFFF);
    wr(IDX_TGT_BAND, 32'hFFFF_FFFF);
    sup({32'h0, 32'h0, 32'h4000_0000, 32'h5}, 0, 0, 0, 0);
    // A one-cycle gap in the excess must restart the timeout
    wr(IDX_TRK_LIMIT, 32'h64);
    fe_reaction_en <= 1'h0;
    pos <= {32'h0, 32'h3E8, 32'h65, 32'h5};
    repeat (15) @(posedge hclk);
    pos <= {32'h0, 32'h3E8, 32'h0, 32'h5};
    @(posedge hclk);
    sup({32'h0, 32'h3E8, 32'h65, 32'h5}, 0, 0, 1, 0);
    check("err_log_off", 32'h1, logs);
    repeat (4) @(posedge hclk);
    check("pending", 32'h0, exp_q.size());
    finish_test();
  end
endmodule // dmpm_top_tb
